// >>> shared/csp_defs.svh
// timing counts, addresses, command codes and reset values of the charger port
// assumes inclusion by bare name from the package and design files
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
`define CSP_SLAVE_ADDR      7'h09
`define CSP_CMD_OPTION      8'h12
`define CSP_CMD_CHG_CURRENT 8'h14
`define CSP_CMD_CHG_VOLTAGE 8'h15
`define CSP_CMD_IN_CURRENT  8'h3f
`define CSP_CMD_MAKER       8'hfe
`define CSP_CMD_PART        8'hff
`define CSP_RST_OPTION      16'h7904
`define CSP_RST_CHG_CURRENT 16'h0000
`define CSP_RST_CHG_VOLTAGE 16'h0000
`define CSP_RST_IN_CURRENT  16'h1000
`define CSP_CLK_HZ          10000000
`define CSP_SCL_HZ          50000
`define CSP_HALF_CYCLES     (`CSP_CLK_HZ / `CSP_SCL_HZ / 2)
`endif

// >>> shared/csp_pkg.sv
// types shared by both ends of the charger port
// assumes csp_defs.svh on the include path
package csp_pkg;
`include "csp_defs.svh"
    typedef enum logic [3:0] {
        CSP_S_IDLE  = 4'b0000,
        CSP_S_ADDR  = 4'b0001,
        CSP_S_ACK   = 4'b0010,
        CSP_S_RX    = 4'b0011,
        CSP_S_TX    = 4'b0100,
        CSP_S_TXACK = 4'b0101,
        CSP_S_WAIT  = 4'b0110
    } csp_dev_state_t;
    typedef enum logic [3:0] {
        CSP_H_IDLE  = 4'b0000,
        CSP_H_START = 4'b0001,
        CSP_H_BIT   = 4'b0010,
        CSP_H_RSTRT = 4'b0011,
        CSP_H_STOP  = 4'b0100,
        CSP_H_DONE  = 4'b0101
    } csp_host_state_t;
endpackage

// >>> shared/csp_bus_if.sv
// two-wire bus between host and charger port; resolves open-drain levels
// assumes both ends drive only low through their enables
`timescale 1ns/1ps
interface csp_bus_if;
    logic sclHostOe;
    logic sdaHostOe;
    logic sdaDevOe;
    logic scl;
    logic sda;
    assign scl = ~sclHostOe;
    assign sda = ~(sdaHostOe | sdaDevOe);
    modport host (output sclHostOe, output sdaHostOe, input scl, input sda);
    modport dev  (output sdaDevOe, input scl, input sda);
endinterface

// >>> hw/csp_device.sv
// charger port: two-wire slave holding the setting and identity words
// assumes bus levels resolved by csp_bus_if; supplyOk and adapterOk are pins
//
// What this block does
// - acts only as slave, never starts
// - answers only address 0001001
// - active only with supply and adapter good
// - start resets byte framing
// - stop ends transfer, wait for start
// - sda changes only while scl low
// - eight-bit bytes, msb first, rising sample
// - ninth clock carries acknowledge
// - word write: addr, command, low, high
// - word read: command, restart, low, high
// - four setting words read and write
// - two read-only identity words
//
// The four parallel setting-word outputs are this design's own decision.
`timescale 1ns/1ps
`include "csp_defs.svh"
module csp_device
    import csp_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h005a  // arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    csp_bus_if.dev           bus,
    input  wire logic        supplyOk,
    input  wire logic        adapterOk,
    output logic [15:0]      chargerOptionBits,
    output logic [15:0]      batteryCurrentLimit,
    output logic [15:0]      batteryVoltageLimit,
    output logic [15:0]      adapterCurrentLimit
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclSync_q, sdaSync_q;
    logic [3:0] enSync_q;     // supply and adapter, two stages each
    logic       sclOld_q, sdaOld_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            enSync_q  <= 4'h0;
            sclOld_q  <= 1'b1;
            sdaOld_q  <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], bus.scl};
            sdaSync_q <= {sdaSync_q[0], bus.sda};
            enSync_q  <= {enSync_q[1:0], supplyOk, adapterOk};
            sclOld_q  <= sclSync_q[1];
            sdaOld_q  <= sdaSync_q[1];
        end
    end
    logic scl, sda, enabled, sclRise, sclFall, startSeen, stopSeen;
    assign scl       = sclSync_q[1];
    assign sda       = sdaSync_q[1];
    assign enabled   = enSync_q[3] & enSync_q[2];
    assign sclRise   = scl & ~sclOld_q;
    assign sclFall   = ~scl & sclOld_q;
    assign startSeen = scl & sclOld_q & sdaOld_q & ~sda;
    assign stopSeen  = scl & sclOld_q & ~sdaOld_q & sda;

    // ------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------
    csp_dev_state_t state_q;
    logic [2:0]  bitCnt_q;
    logic [7:0]  shift_q, cmd_q, lowByte_q;
    logic [1:0]  byteIdx_q;    // 0 command, 1 low, 2 high
    logic        readDir_q, ackIt_q, sdaOe_q, hiByte_q;
    logic        afterAddr_q;  // current ack slot follows the address byte
    logic [15:0] readWord;
    logic        cmdKnown, cmdWritable;

    always_comb begin
        unique case (cmd_q)
            `CSP_CMD_OPTION:      readWord = chargerOptionBits;
            `CSP_CMD_CHG_CURRENT: readWord = batteryCurrentLimit;
            `CSP_CMD_CHG_VOLTAGE: readWord = batteryVoltageLimit;
            `CSP_CMD_IN_CURRENT:  readWord = adapterCurrentLimit;
            `CSP_CMD_MAKER:       readWord = MAKER_CODE;
            `CSP_CMD_PART:        readWord = PART_CODE;
            default:              readWord = 16'h0000;
        endcase
    end
    function automatic logic known(input logic [7:0] c);
        known = (c == `CSP_CMD_OPTION) || (c == `CSP_CMD_CHG_CURRENT) ||
                (c == `CSP_CMD_CHG_VOLTAGE) || (c == `CSP_CMD_IN_CURRENT) ||
                (c == `CSP_CMD_MAKER) || (c == `CSP_CMD_PART);
    endfunction
    assign cmdKnown    = known(shift_q);
    assign cmdWritable = known(cmd_q) && (cmd_q != `CSP_CMD_MAKER) &&
                         (cmd_q != `CSP_CMD_PART);

    logic [7:0] rxByte;
    assign rxByte = {shift_q[6:0], sda};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q   <= CSP_S_IDLE;
            bitCnt_q  <= 3'h0;
            shift_q   <= 8'h00;
            cmd_q     <= 8'h00;
            lowByte_q <= 8'h00;
            byteIdx_q <= 2'h0;
            readDir_q <= 1'b0;
            ackIt_q   <= 1'b0;
            sdaOe_q   <= 1'b0;
            hiByte_q  <= 1'b0;
            afterAddr_q <= 1'b0;
        end else if (!enabled || stopSeen) begin
            state_q <= CSP_S_IDLE;
            sdaOe_q <= 1'b0;
        end else if (startSeen) begin
            state_q  <= CSP_S_ADDR;
            bitCnt_q <= 3'h0;
            hiByte_q <= 1'b0;
            sdaOe_q  <= 1'b0;
        end else begin
            unique case (state_q)
                CSP_S_IDLE, CSP_S_WAIT: sdaOe_q <= 1'b0;
                CSP_S_ADDR, CSP_S_RX: begin
                    if (sclRise) begin
                        shift_q  <= rxByte;
                        bitCnt_q <= bitCnt_q + 3'h1;
                    end
                    // only a fall after the eighth rise closes a byte; the
                    // fall that ends a start must not
                    if (sclFall && bitCnt_q == 3'h0 && hiByte_q) begin
                        hiByte_q <= 1'b0;
                        if (state_q == CSP_S_ADDR) begin
                            ackIt_q   <= (shift_q[7:1] == `CSP_SLAVE_ADDR);
                            readDir_q <= shift_q[0];
                            if (shift_q[7:1] != `CSP_SLAVE_ADDR)
                                state_q <= CSP_S_WAIT;
                            else begin
                                state_q <= CSP_S_ACK;
                                sdaOe_q <= 1'b1;
                                afterAddr_q <= 1'b1;
                            end
                        end else begin
                            unique case (byteIdx_q)
                                2'h0: begin
                                    cmd_q   <= shift_q;
                                    ackIt_q <= cmdKnown;
                                end
                                2'h1: begin
                                    lowByte_q <= shift_q;
                                    ackIt_q   <= 1'b1;
                                end
                                default: ackIt_q <= 1'b1;
                            endcase
                            state_q <= CSP_S_ACK;
                            sdaOe_q <= (byteIdx_q != 2'h0) | cmdKnown;
                        end
                    end
                    if (sclRise && bitCnt_q == 3'h7)
                        hiByte_q <= 1'b1;
                end
                CSP_S_ACK: begin
                    if (sclFall) begin
                        sdaOe_q     <= 1'b0;
                        afterAddr_q <= 1'b0;
                        bitCnt_q    <= 3'h0;
                        if (!ackIt_q)
                            state_q <= CSP_S_WAIT;
                        else if (readDir_q) begin
                            state_q <= CSP_S_TX;
                            if (afterAddr_q) begin
                                byteIdx_q <= 2'h1;
                                shift_q   <= readWord[7:0];
                                sdaOe_q   <= ~readWord[7];
                            end else begin
                                shift_q <= readWord[15:8];
                                sdaOe_q <= ~readWord[15];
                            end
                        end else if (!afterAddr_q && byteIdx_q == 2'h2)
                            state_q <= CSP_S_WAIT;
                        else
                            state_q <= CSP_S_RX;
                    end
                end
                CSP_S_TX: begin
                    if (sclFall) begin
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == 3'h7) begin
                            sdaOe_q <= 1'b0;
                            state_q <= CSP_S_TXACK;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sdaOe_q <= ~shift_q[6];
                        end
                    end
                end
                CSP_S_TXACK: begin
                    if (sclRise) begin
                        if (sda || byteIdx_q == 2'h2)
                            state_q <= CSP_S_WAIT;
                        else begin
                            byteIdx_q <= 2'h2;
                            state_q   <= CSP_S_ACK;
                            ackIt_q   <= 1'b1;
                        end
                    end
                end
                default: state_q <= CSP_S_IDLE;
            endcase
            if (startSeen || state_q == CSP_S_IDLE)
                byteIdx_q <= 2'h0;
            if (state_q == CSP_S_ADDR && sclFall && bitCnt_q == 3'h0 &&
                hiByte_q && !shift_q[0])
                byteIdx_q <= 2'h0;
            if (state_q == CSP_S_ACK && sclFall && ackIt_q && !readDir_q &&
                !afterAddr_q)
                byteIdx_q <= (byteIdx_q == 2'h2) ? 2'h2 : byteIdx_q + 2'h1;
        end
    end
    assign bus.sdaDevOe = sdaOe_q;

    // ------------------------------------------------------------
    // setting words
    // ------------------------------------------------------------
    logic wrWord;
    assign wrWord = enabled && !stopSeen && !startSeen &&
                    state_q == CSP_S_ACK && sclFall && !readDir_q &&
                    byteIdx_q == 2'h2 && cmdWritable;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            chargerOptionBits   <= `CSP_RST_OPTION;
            batteryCurrentLimit <= `CSP_RST_CHG_CURRENT;
            batteryVoltageLimit <= `CSP_RST_CHG_VOLTAGE;
            adapterCurrentLimit <= `CSP_RST_IN_CURRENT;
        end else if (wrWord) begin
            if (cmd_q == `CSP_CMD_OPTION)
                chargerOptionBits <= {shift_q, lowByte_q};
            if (cmd_q == `CSP_CMD_CHG_CURRENT)
                batteryCurrentLimit <= {shift_q, lowByte_q};
            if (cmd_q == `CSP_CMD_CHG_VOLTAGE)
                batteryVoltageLimit <= {shift_q, lowByte_q};
            if (cmd_q == `CSP_CMD_IN_CURRENT)
                adapterCurrentLimit <= {shift_q, lowByte_q};
        end
    end
endmodule

// >>> hw/csp_host.sv
// host end: two-wire master issuing word writes and word reads
// assumes bus levels resolved by csp_bus_if; one request at a time
`timescale 1ns/1ps
`include "csp_defs.svh"
module csp_host
    import csp_pkg::*;
#(
    parameter int HALF = `CSP_HALF_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    csp_bus_if.host          bus,
    input  wire logic        reqWrite,
    input  wire logic        reqRead,
    input  wire logic [7:0]  reqCmd,
    input  wire logic [15:0] reqData,
    output logic             busy,
    output logic             done_q,
    output logic             nack_q,
    output logic [15:0]      rdData_q
);
    if (HALF < 2 || HALF > 65535) begin : g_half_check
        $error("HALF out of range");
    end
    logic [1:0] sdaSync_q;
    always_ff @(posedge core_clk) begin
        if (reset) sdaSync_q <= 2'h3;
        else sdaSync_q <= {sdaSync_q[0], bus.sda};
    end
    // ------------------------------------------------------------
    // bit sequencer: each bit is four quarter phases of HALF/2+1 cycles
    // ------------------------------------------------------------
    csp_host_state_t state_q;
    logic [15:0] tick_q;
    logic [1:0]  phase_q;
    logic [5:0]  bitIdx_q;
    logic [44:0] frame_q;  // bits to send, msb first, 1 = release
    logic [5:0]  frameLen_q, restartAt_q;
    logic        isRead_q, sclOe_q, sdaOe_q;
    logic [15:0] rx_q;
    logic        quarter;
    assign quarter = (tick_q == 16'(HALF / 2));
    assign busy    = (state_q != CSP_H_IDLE);
    assign bus.sclHostOe = sclOe_q;
    assign bus.sdaHostOe = sdaOe_q;
    always_ff @(posedge core_clk) begin
        if (reset || state_q == CSP_H_IDLE || quarter) tick_q <= 16'h0000;
        else tick_q <= tick_q + 16'h0001;
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= CSP_H_IDLE;
            phase_q <= 2'h0; bitIdx_q <= 6'h00; frame_q <= '0;
            frameLen_q <= 6'h00; restartAt_q <= 6'h00; isRead_q <= 1'b0;
            sclOe_q <= 1'b0; sdaOe_q <= 1'b0; rx_q <= 16'h0000;
            done_q <= 1'b0; nack_q <= 1'b0; rdData_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                CSP_H_IDLE: if (reqWrite || reqRead) begin
                    isRead_q <= reqRead; nack_q <= 1'b0;
                    phase_q <= 2'h0; bitIdx_q <= 6'h00;
                    state_q <= CSP_H_START;
                    if (reqRead) begin
                        frame_q <= {`CSP_SLAVE_ADDR, 1'b0, 1'b1, reqCmd, 1'b1,
                                    `CSP_SLAVE_ADDR, 1'b1, 1'b1, 8'hff, 1'b0,
                                    8'hff, 1'b1};
                        frameLen_q <= 6'd45; restartAt_q <= 6'd18;
                    end else begin
                        frame_q <= {`CSP_SLAVE_ADDR, 1'b0, 1'b1, reqCmd, 1'b1,
                                    reqData[7:0], 1'b1, reqData[15:8], 1'b1,
                                    9'h1ff}; // pad keeps first bit on top
                        frameLen_q <= 6'd36; restartAt_q <= 6'd63;
                    end
                end
                CSP_H_START, CSP_H_RSTRT: if (quarter) begin
                    phase_q <= phase_q + 2'h1;
                    unique case (phase_q)
                        2'h0: begin sdaOe_q <= 1'b0; sclOe_q <= 1'b1; end
                        2'h1: sclOe_q <= 1'b0;
                        2'h2: sdaOe_q <= 1'b1;       // sda falls, scl high
                        2'h3: begin sclOe_q <= 1'b1; state_q <= CSP_H_BIT; end
                    endcase
                end
                CSP_H_BIT: if (quarter) begin
                    phase_q <= phase_q + 2'h1;
                    unique case (phase_q)
                        2'h0: sdaOe_q <= ~frame_q[44]; // change with scl low
                        2'h1: sclOe_q <= 1'b0;
                        2'h2: begin
                            if (isRead_q && bitIdx_q >= 6'd27 &&
                                bitIdx_q <= 6'd43 && bitIdx_q != 6'd35)
                                rx_q <= {rx_q[14:0], sdaSync_q[1]};
                            if ((bitIdx_q == 6'd8 || bitIdx_q == 6'd17 ||
                                 bitIdx_q == 6'd26 ||
                                 (!isRead_q && bitIdx_q == 6'd35)) &&
                                sdaSync_q[1])
                                nack_q <= 1'b1;
                        end
                        2'h3: begin
                            sclOe_q  <= 1'b1;
                            frame_q  <= {frame_q[43:0], 1'b1};
                            bitIdx_q <= bitIdx_q + 6'h01;
                            if (bitIdx_q + 6'h01 == frameLen_q || nack_q)
                                state_q <= CSP_H_STOP;
                            else if (bitIdx_q + 6'h01 == restartAt_q)
                                state_q <= CSP_H_RSTRT;
                        end
                    endcase
                end
                CSP_H_STOP: if (quarter) begin
                    phase_q <= phase_q + 2'h1;
                    unique case (phase_q)
                        2'h0: sdaOe_q <= 1'b1;
                        2'h1: sclOe_q <= 1'b0;
                        2'h2: sdaOe_q <= 1'b0;   // sda rises, scl high
                        2'h3: state_q <= CSP_H_DONE;
                    endcase
                end
                CSP_H_DONE: begin
                    done_q <= 1'b1;
                    rdData_q <= {rx_q[7:0], rx_q[15:8]};
                    state_q <= CSP_H_IDLE;
                end
                default: state_q <= CSP_H_IDLE;
            endcase
        end
    end
endmodule

// >>> test/csp_monitor.sv
// concurrent checks on the two-wire bus between host and charger port
// assumes one host and one device, levels resolved by csp_bus_if
`timescale 1ns/1ps
`include "csp_defs.svh"
module csp_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclHostOe,
    input wire logic sdaHostOe,
    input wire logic sdaDevOe,
    input wire logic scl,
    input wire logic sda
);
    // ------------------------------------------------------------
    // framing tracker, rebuilt from the wire alone
    // ------------------------------------------------------------
    logic       sclQ, sdaQ, busIdle_q, rdMode_q;
    logic [3:0] bitCnt_q;
    logic [2:0] byteCnt_q;
    logic [7:0] shift_q;
    logic       sclRise, startSeen, stopSeen, ackSlot, cmdKnown;
    assign sclRise   = scl && !sclQ;
    assign startSeen = scl && sclQ && sdaQ && !sda;
    assign stopSeen  = scl && sclQ && !sdaQ && sda;
    assign ackSlot   = sclRise && bitCnt_q == 4'd8;
    assign cmdKnown  = shift_q inside {`CSP_CMD_OPTION, `CSP_CMD_CHG_CURRENT,
        `CSP_CMD_CHG_VOLTAGE, `CSP_CMD_IN_CURRENT, `CSP_CMD_MAKER,
        `CSP_CMD_PART};
    always_ff @(posedge core_clk) begin
        sclQ <= scl;
        sdaQ <= sda;
    end
    always_ff @(posedge core_clk) begin
        if (reset || stopSeen) busIdle_q <= 1'b1;
        else if (startSeen) busIdle_q <= 1'b0;
    end
    // shift stops on the ninth clock so the byte stays for the ack check
    always_ff @(posedge core_clk) begin
        if (sclRise && bitCnt_q != 4'd8) shift_q <= {shift_q[6:0], sda};
    end
    always_ff @(posedge core_clk) begin
        if (reset || startSeen || stopSeen) begin
            bitCnt_q  <= 4'd0;
            byteCnt_q <= 3'd0;
            rdMode_q  <= 1'b0;
        end else if (sclRise) begin
            bitCnt_q <= (bitCnt_q == 4'd8) ? 4'd0 : bitCnt_q + 4'd1;
            if (bitCnt_q == 4'd8) byteCnt_q <= byteCnt_q + 3'd1;
            if (ackSlot && byteCnt_q == 3'd0) rdMode_q <= shift_q[0];
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence devAddrAck;
        ackSlot && byteCnt_q == 3'd0 && sdaDevOe;
    endsequence
    sequence unkCmdAck;
        ackSlot && byteCnt_q == 3'd1 && !rdMode_q && !cmdKnown;
    endsequence
    sequence lowByteAck;
        ackSlot && byteCnt_q == 3'd1 && rdMode_q;
    endsequence
    sequence highByteAck;
        ackSlot && byteCnt_q == 3'd2 && rdMode_q;
    endsequence
    dev_no_start_a: assert property ($rose(sdaDevOe) |-> !scl)
        else $error("device pulled data low while clock high");
    addr_match_a: assert property (devAddrAck |->
        shift_q[7:1] == `CSP_SLAVE_ADDR) else $error("foreign address acked");
    start_free_a: assert property (startSeen |-> !sdaDevOe)
        else $error("device holds data across a start");
    idle_free_a: assert property (busIdle_q |-> !sdaDevOe)
        else $error("device drives an idle bus");
    dev_steady_a: assert property (scl && sclQ |-> $stable(sdaDevOe))
        else $error("device data moved while clock high");
    host_steady_a: assert property (sclRise |-> $stable(sdaHostOe))
        else $error("host data moved at clock rise");
    frame_drive_a: assert property (sclRise && sdaDevOe |->
        ((bitCnt_q == 4'd8) ? (!rdMode_q || byteCnt_q == 3'd0)
                            : (rdMode_q && byteCnt_q != 3'd0)))
        else $error("device drove outside its slots");
    whole_bytes_a: assert property ((startSeen || stopSeen) &&
        !busIdle_q |-> bitCnt_q == 4'd1) else $error("frame cut mid byte");
    unk_cmd_a: assert property (unkCmdAck |-> !sdaDevOe)
        else $error("unknown command acked");
    low_ack_a: assert property (lowByteAck |-> sdaHostOe)
        else $error("host did not ack low byte");
    high_nack_a: assert property (highByteAck |-> !sdaHostOe && sda)
        else $error("high byte not refused by host");
endmodule

// >>> test/charger_smbus_slave_port_bench.sv
// self-checking bench: host and charger port joined over the two-wire bus
// assumes the shared header and interface are compiled before this file
`timescale 1ns/1ps
`include "csp_defs.svh"
module charger_smbus_slave_port_bench;
    typedef struct {
        logic        nack;
        logic        useData;
        logic [15:0] data;
        logic [15:0] words [4];
    } csp_note_t;
    localparam logic [15:0] MAKER = 16'h0c3d; // arbitrary value
    localparam logic [15:0] PART  = 16'h0e71; // arbitrary value
    localparam logic [7:0]  CMDS [4] = '{`CSP_CMD_OPTION,
        `CSP_CMD_CHG_CURRENT, `CSP_CMD_CHG_VOLTAGE, `CSP_CMD_IN_CURRENT};
    localparam logic [15:0] RSTS [4] = '{`CSP_RST_OPTION,
        `CSP_RST_CHG_CURRENT, `CSP_RST_CHG_VOLTAGE, `CSP_RST_IN_CURRENT};
    logic        core_clk, reset, supplyOk, adapterOk, reqWrite, reqRead;
    logic [7:0]  reqCmd;
    logic [15:0] reqData, rdData;
    logic        busy, done, nack;
    logic [15:0] word [4];
    logic [15:0] expWord [4];
    csp_note_t   notes [$];
    csp_note_t   cur;
    int          numErrors, checkCount, cycles, r;
    // ------------------------------------------------------------
    // structure
    // ------------------------------------------------------------
    csp_bus_if bus ();
    csp_host #(.HALF(4)) u_csp_host (.core_clk(core_clk), .reset(reset),
        .bus(bus), .reqWrite(reqWrite), .reqRead(reqRead), .reqCmd(reqCmd),
        .reqData(reqData), .busy(busy), .done_q(done), .nack_q(nack),
        .rdData_q(rdData));
    csp_device #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_csp_device (
        .core_clk(core_clk), .reset(reset), .bus(bus), .supplyOk(supplyOk),
        .adapterOk(adapterOk), .chargerOptionBits(word[0]),
        .batteryCurrentLimit(word[1]), .batteryVoltageLimit(word[2]),
        .adapterCurrentLimit(word[3]));
    csp_monitor u_csp_monitor (.core_clk(core_clk), .reset(reset),
        .sclHostOe(bus.sclHostOe), .sdaHostOe(bus.sdaHostOe),
        .sdaDevOe(bus.sdaDevOe), .scl(bus.scl), .sda(bus.sda));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checkCount++;
        if (g !== e) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic int idxOf(input logic [7:0] c);
        idxOf = 7;
        for (int i = 0; i < 4; i++) if (CMDS[i] === c) idxOf = i;
        if (c === `CSP_CMD_MAKER) idxOf = 4;
        if (c === `CSP_CMD_PART) idxOf = 5;
    endfunction
    task doReset;
        reset <= 1'b1;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        expWord = RSTS;
        @(posedge core_clk);
    endtask
    // the note is queued before the request, so the watcher never races it
    task automatic doTxn(input logic wr, input logic [7:0] cmd,
                         input logic [15:0] d);
        csp_note_t n;
        int        i;
        int        k;
        i = idxOf(cmd);
        n.nack = !(supplyOk && adapterOk) || i == 7;
        n.useData = !wr && !n.nack;
        n.data = (i < 4) ? expWord[i] : ((i == 4) ? MAKER : PART);
        if (wr && !n.nack && i < 4) expWord[i] = d;
        n.words = expWord;
        notes.push_back(n);
        reqWrite <= wr;
        reqRead <= !wr;
        reqCmd <= cmd;
        reqData <= d;
        @(posedge core_clk);
        reqWrite <= 1'b0;
        reqRead <= 1'b0;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (busy !== 1'b0 && k < 2000);
        if (busy !== 1'b0) begin
            numErrors++;
            $display("[FAIL] busy expected 0 seen %b", busy);
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            numErrors++;
            $display("[FAIL] run timeout expected done seen hang");
            finish_test();
        end else if (!reset && done === 1'b1 && notes.size() > 0) begin
            cur = notes.pop_front();
            chk("refusal flag", {15'h0000, cur.nack}, {15'h0000, nack});
            if (cur.useData) chk("read word", cur.data, rdData);
            for (int i = 0; i < 4; i++) chk("setting", cur.words[i], word[i]);
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {reset, supplyOk, adapterOk, reqWrite, reqRead} = 5'b11100;
        reqCmd = 8'h00;
        reqData = 16'h0000;
        r = $urandom(32'hd0ef00d1);
        doReset();
        for (int i = 0; i < 4; i++) chk("reset word", RSTS[i], word[i]);
        for (int i = 0; i < 4; i++) begin
            doTxn(1'b1, CMDS[i], 16'($urandom));
            doTxn(1'b0, CMDS[i], 16'h0000);
        end
        doTxn(1'b0, `CSP_CMD_MAKER, 16'h0000);
        doTxn(1'b1, `CSP_CMD_PART, 16'($urandom));
        doTxn(1'b0, `CSP_CMD_PART, 16'h0000);
        doTxn(1'b1, 8'h13, 16'($urandom));
        doTxn(1'b0, 8'h00, 16'h0000);
        for (int j = 0; j < 2; j++) begin
            {supplyOk, adapterOk} <= (j == 0) ? 2'b01 : 2'b10;
            repeat (4) @(posedge core_clk);
            doTxn(1'b1, CMDS[1], 16'($urandom));
            doTxn(1'b0, CMDS[1], 16'h0000);
        end
        {supplyOk, adapterOk} <= 2'b11;
        repeat (4) @(posedge core_clk);
        for (int j = 0; j < 6; j++) begin
            doTxn(1'b1, CMDS[$urandom_range(3)], 16'($urandom));
        end
        doTxn(1'b0, CMDS[2], 16'h0000);
        repeat (5) @(posedge core_clk);
        doReset();
        for (int i = 0; i < 4; i++) chk("reset word", RSTS[i], word[i]);
        chk("open notes", 16'h0000, 16'(notes.size()));
        finish_test();
    end
endmodule
